/* File: hw/qsc_pkg.sv */
// Constants for the quad converter sequencer control block.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
//
// Notes on behaviour
// - Timed and FIFO updates of a group are spaced (preload + 1) x 10 us.
// - Interval time base comes from the board clock, in 10 us steps.
// - Each group has a clear bit in bits 7:0; set bit holds clear asserted.
// - Group clear forces its channels to the selected clear value.
// - Load bit per group in bits 7:0, acts only in manual-update mode.
// - Logged load updates outputs only after pending channel data is sent.
// - Global manual groups update together once every one is ready.
// - Hardware clears a load bit when that group's outputs update.
// - Channel data is forwarded at once, never waiting for a load.
// - Global control bit 8 is the master interrupt enable.
// - Run bits 7:0 start a group sequencer on 1 and stop it on 0.
// - Busy stays set while the group sequencer runs.
// - Stop lets a running transfer finish; software polls busy.
// - Reserved upper bits are written as zero; reads here return zero.
// - Busy reads clear only when group control logic is idle.
`default_nettype none
package qsc_pkg;
  localparam int unsigned NGRP = 8;
  localparam logic [11:0] OFS_PRELOAD = 12'h060; // Eight words, one per group.
  localparam logic [11:0] OFS_CLEAR   = 12'h080;
  localparam logic [11:0] OFS_LOAD    = 12'h084;
  localparam logic [11:0] OFS_GCTRL   = 12'h088;
  localparam logic [11:0] OFS_GSTAT   = 12'h08C;
  localparam int unsigned MIE_BIT     = 8;
  localparam int unsigned BUSY_STRIDE = 4;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // Time base: one tick every 10 us at the pclk rate.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 10000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  TICK_LAST     = 10'(TICK_CYC - 1);
  // Converter group modes as driven by the group control register.
  typedef enum logic [1:0] {
    MODE_IMM = 2'b00,
    MODE_MAN = 2'b01,
    MODE_TIM = 2'b10,
    MODE_FIFO = 2'b11
  } qsc_mode_t;
  // Sequencer states, Gray coded along idle, run, drain.
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_RUN   = 2'b01,
    SEQ_DRAIN = 2'b11
  } qsc_seq_t;
endpackage
`default_nettype wire

/* File: hw/qsc_tick_gen.sv */
// Shared 10 us time base divider.
// Assumes a single pclk domain with asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module qsc_tick_gen
  import qsc_pkg::*;
(
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Asynchronous reset, active low.
  output logic      tick     // One-cycle pulse every 10 us.
);
  logic [9:0] div_reg;

  // Divide the clock down to one enable pulse per tick period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 10'h000;
      tick    <= 1'b0;
    end else begin
      tick <= (div_reg == TICK_LAST);
      if (div_reg == TICK_LAST) begin
        div_reg <= 10'h000;
      end else begin
        div_reg <= div_reg + 10'h001;
      end
    end
  end
endmodule // qsc_tick_gen
`default_nettype wire

/* File: hw/qsc_ctrl.sv */
// Sequencer, clear, load and global control for eight converter groups.
// Assumes transfer logic reports busy and pending data per group.
`timescale 1ns/10ps
`default_nettype none
module qsc_ctrl
  import qsc_pkg::*;
(
  input  wire logic        pclk,          // System clock, 100 MHz.
  input  wire logic        presetn,       // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction, high for write.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic [31:0]      prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error for unmapped address.
  input  wire logic [15:0] group_mode,    // Two mode bits per group.
  input  wire logic [7:0]  global_man,    // Group takes part in global update.
  input  wire logic [7:0]  clear_value_select, // Clear value choice per group.
  input  wire logic [7:0]  xfer_busy,     // Transfer to converter in progress.
  input  wire logic [7:0]  data_pending,  // Channel data waiting to be sent.
  input  wire logic        irq_source,    // Any individually enabled source.
  output logic [7:0]       dac_clear,     // Group clear signals.
  output logic [7:0]       clear_sel_out, // Clear value choice to converter.
  output logic [7:0]       dac_update,    // Analog output update pulses.
  output logic [7:0]       xfer_go,       // Forward pending data now.
  output logic [7:0]       group_busy,    // Busy flags, mirrored in status.
  output logic             irq_out        // Interrupt after master enable.
);
  logic [31:0] preload_reg [NGRP];
  logic [31:0] cnt_reg [NGRP];
  qsc_seq_t    seq_reg [NGRP];
  logic [7:0]  clear_reg;
  logic [7:0]  load_reg;
  logic [7:0]  load_next;
  logic [7:0]  run_reg;
  logic        mie_reg;
  logic        tick;
  logic        wr_en;
  logic        rd_take;
  logic [31:0] rdata;
  logic        rd_ok;
  logic [7:0]  is_man;
  logic [7:0]  gmask;
  logic [7:0]  man_ready;
  logic [7:0]  fire;
  logic [7:0]  seq_upd;
  logic [7:0]  load_set;
  logic        glob_go;

  // True when the bus address selects the given register word.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // Group index for an address inside the preload word window.
  function automatic logic [2:0] pre_idx(input logic [11:0] a);
    pre_idx = a[4:2];
  endfunction

  qsc_tick_gen u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // A write lands in the ready access cycle; read data is taken in the first access cycle, before pready.
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_take = psel && penable && !pready;

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    rdata = RST_WORD;
    rd_ok = 1'b1;
    if (paddr[11:5] == OFS_PRELOAD[11:5]) begin
      rdata = preload_reg[pre_idx(paddr)];
    end else if (hit(paddr, OFS_CLEAR)) begin
      rdata = {24'h00_0000, clear_reg};
    end else if (hit(paddr, OFS_LOAD)) begin
      rdata = {24'h00_0000, load_reg};
    end else if (hit(paddr, OFS_GCTRL)) begin
      rdata = {23'h00_0000, mie_reg, run_reg};
    end else if (hit(paddr, OFS_GSTAT)) begin
      for (int g = 0; g < NGRP; g++) begin
        rdata[g*BUSY_STRIDE] = group_busy[g];
      end
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Bus answer: ready one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      pready <= rd_take;
      if (rd_take) begin
        pslverr <= !rd_ok;
        prdata  <= pwrite ? RST_WORD : rdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Interval preload words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < NGRP; g++) begin
        preload_reg[g] <= RST_WORD;
      end
    end else if (wr_en && paddr[11:5] == OFS_PRELOAD[11:5]) begin
      preload_reg[pre_idx(paddr)] <= pwdata;
    end
  end

  // Clear, run and master enable control bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_reg <= 8'h00;
      run_reg   <= 8'h00;
      mie_reg   <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, OFS_CLEAR)) begin
        clear_reg <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, OFS_GCTRL)) begin
        run_reg <= pwdata[7:0];
        mie_reg <= pwdata[MIE_BIT];
      end
    end
  end

  // Manual update readiness, local and global.
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      is_man[g] = (qsc_mode_t'(group_mode[2*g +: 2]) == MODE_MAN);
    end
    gmask     = is_man & global_man;
    man_ready = load_reg & is_man & ~data_pending & ~xfer_busy & ~clear_reg;
    glob_go   = (&(~gmask | man_ready)) && (|(gmask & man_ready));
    fire      = (man_ready & ~gmask) | (glob_go ? gmask : 8'h00);
  end

  // Load bits: software sets in manual mode only, hardware clears on update.
  assign load_set  = (wr_en && hit(paddr, OFS_LOAD)) ? (pwdata[7:0] & is_man) : 8'h00;
  assign load_next = (load_reg & ~fire) | load_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_reg <= 8'h00;
    end else begin
      load_reg <= load_next;
    end
  end

  // Per-group sequencer state and interval counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < NGRP; g++) begin
        seq_reg[g] <= SEQ_IDLE;
        cnt_reg[g] <= RST_WORD;
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        case (seq_reg[g])
          SEQ_IDLE: begin
            if (run_reg[g]) begin
              seq_reg[g] <= SEQ_RUN;
              cnt_reg[g] <= preload_reg[g];
            end
          end
          SEQ_RUN: begin
            if (!run_reg[g]) begin
              seq_reg[g] <= SEQ_DRAIN;
            end else if (tick) begin
              if (cnt_reg[g] == RST_WORD) begin
                cnt_reg[g] <= preload_reg[g];
              end else begin
                cnt_reg[g] <= cnt_reg[g] - 32'h0000_0001;
              end
            end
          end
          SEQ_DRAIN: begin
            if (run_reg[g]) begin
              seq_reg[g] <= SEQ_RUN;
              cnt_reg[g] <= preload_reg[g];
            end else if (!xfer_busy[g]) begin
              seq_reg[g] <= SEQ_IDLE;
            end
          end
          default: begin
            seq_reg[g] <= SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // Timed and FIFO updates fire when the counter expires on a tick.
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      seq_upd[g] = (seq_reg[g] == SEQ_RUN) && run_reg[g] && tick &&
                   (cnt_reg[g] == RST_WORD) && group_mode[2*g+1];
    end
  end

  // Registered outputs toward the converters and the status view.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_clear     <= 8'h00;
      clear_sel_out <= 8'h00;
      dac_update    <= 8'h00;
      xfer_go       <= 8'h00;
      group_busy    <= 8'h00;
      irq_out       <= 1'b0;
    end else begin
      dac_clear     <= clear_reg;
      clear_sel_out <= clear_value_select;
      dac_update    <= seq_upd | fire;
      xfer_go       <= data_pending;
      for (int g = 0; g < NGRP; g++) begin
        group_busy[g] <= (seq_reg[g] != SEQ_IDLE) || run_reg[g] ||
                         xfer_busy[g] || load_reg[g];
      end
      irq_out <= mie_reg && irq_source;
    end
  end

  // Checks on the control behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_interval_reload;
    seq_upd[0] |=> (cnt_reg[0] == $past(preload_reg[0]));
  endproperty
  a_interval_reload: assert property (p_interval_reload)
    else $error("Interval counter did not reload after update.");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Time base ticks too close together.");

  property p_clear_out;
    (wr_en && hit(paddr, OFS_CLEAR)) |=> ##1 (dac_clear == $past(pwdata[7:0], 2));
  endproperty
  a_clear_out: assert property (p_clear_out)
    else $error("Clear output does not follow clear write.");

  property p_load_ignored;
    (wr_en && hit(paddr, OFS_LOAD) && pwdata[0] && !is_man[0] && !load_reg[0])
      |=> !load_reg[0];
  endproperty
  a_load_ignored: assert property (p_load_ignored)
    else $error("Load bit set outside manual mode.");

  property p_load_autoclear;
    (fire[0] && !load_set[0]) |=> (!load_reg[0] && dac_update[0]);
  endproperty
  a_load_autoclear: assert property (p_load_autoclear)
    else $error("Load bit not cleared at update.");

  property p_wait_data;
    (data_pending[0] && seq_reg[0] == SEQ_IDLE && !run_reg[0]) |=> !dac_update[0];
  endproperty
  a_wait_data: assert property (p_wait_data)
    else $error("Manual update before channel data was sent.");

  property p_global_wait;
    (gmask[2:1] == 2'b11 && man_ready[1] && !man_ready[2] && !run_reg[1])
      |=> !dac_update[1];
  endproperty
  a_global_wait: assert property (p_global_wait)
    else $error("Global group updated before all were ready.");

  property p_busy_run;
    (seq_reg[1] == SEQ_RUN) |=> group_busy[1];
  endproperty
  a_busy_run: assert property (p_busy_run)
    else $error("Busy dropped while sequencer runs.");

  property p_drain_hold;
    (seq_reg[0] == SEQ_DRAIN && xfer_busy[0]) |=> (seq_reg[0] != SEQ_IDLE);
  endproperty
  a_drain_hold: assert property (p_drain_hold)
    else $error("Sequencer stopped during a transfer.");

  property p_start;
    (seq_reg[0] == SEQ_IDLE && run_reg[0]) |=> (seq_reg[0] == SEQ_RUN) ##1 group_busy[0];
  endproperty
  a_start: assert property (p_start)
    else $error("Run bit did not start the sequencer.");

  property p_mie;
    !mie_reg |=> !irq_out;
  endproperty
  a_mie: assert property (p_mie)
    else $error("Interrupt raised with master enable off.");

  property p_busy_idle;
    !group_busy[0] |-> $past(seq_reg[0] == SEQ_IDLE);
  endproperty
  a_busy_idle: assert property (p_busy_idle)
    else $error("Busy clear while control logic not idle.");

  c_seq_update: cover property (seq_upd[0] && seq_upd[1]);
  c_global_fire: cover property (glob_go && gmask[2:1] == 2'b11);
  c_drain: cover property (seq_reg[0] == SEQ_DRAIN ##1 seq_reg[0] == SEQ_IDLE);
endmodule // qsc_ctrl
`default_nettype wire

/* File: verif/qsc_dac_model.sv */
// Transfer logic and converter model on the far side of the control block.
// Assumes the block raises xfer_go while channel data is pending.
`timescale 1ns/10ps
`default_nettype none
module qsc_dac_model #(
  parameter int XFER_CYC = 20 // One channel data transfer keeps busy set for XFER_CYC + 1 cycles.
) (
  input  wire logic       pclk,         // System clock.
  input  wire logic       presetn,      // Asynchronous reset, active low.
  input  wire logic [7:0] xfer_go,      // Forward request from the block.
  input  wire logic [7:0] new_data,     // Pulse: channel data written.
  output logic      [7:0] xfer_busy,    // Transfer in progress.
  output logic      [7:0] data_pending  // Data not yet in the converter.
);
  logic [7:0] cnt [8];
  // Each group runs one transfer at a time and always lets it finish.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_busy <= 8'h00;
      data_pending <= 8'h00;
      for (int g = 0; g < 8; g++) cnt[g] <= 8'h00;
    end else begin
      for (int g = 0; g < 8; g++) begin
        if (xfer_go[g] && data_pending[g] && !xfer_busy[g]) begin
          xfer_busy[g] <= 1'b1;
          cnt[g] <= 8'(XFER_CYC);
        end else if (xfer_busy[g]) begin
          cnt[g] <= cnt[g] - 8'h01;
          if (cnt[g] == 8'h00) begin
            xfer_busy[g] <= 1'b0;
            data_pending[g] <= 1'b0;
          end
        end
        if (new_data[g]) data_pending[g] <= 1'b1;
      end
    end
  end
endmodule // qsc_dac_model
`default_nettype wire

/* File: verif/qsc_tb.sv */
// Self-checking bench for the sequencer control block over APB.
// Assumes the transfer model qsc_dac_model and a 100 MHz pclk.
`timescale 1ns/10ps
`default_nettype none
module quad_converter_sequencer_control_tb_top;
  import qsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_source, irq_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] group_mode;
  logic [7:0]  global_man, clear_value_select, xfer_busy, data_pending, dac_clear;
  logic [7:0]  clear_sel_out, dac_update, xfer_go, group_busy, new_data;
  logic        err;
  int          miscompares, cmp_count, n;

  qsc_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .group_mode, .global_man, .clear_value_select, .xfer_busy,
    .data_pending, .irq_source, .dac_clear, .clear_sel_out, .dac_update, .xfer_go,
    .group_busy, .irq_out);
  qsc_dac_model model_u (.pclk, .presetn, .xfer_go, .new_data, .xfer_busy, .data_pending);

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    // Answer is taken at the edge where pready is sampled high, then released.
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask

  // Waits for an update pulse of group g; n holds the cycles waited.
  task automatic wait_upd(input int g, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (dac_update[g] !== 1'b1 && n < lim);
    if (n >= lim) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // Pulses the written-data strobe of the model.
  task automatic push(input logic [7:0] m);
    @(posedge pclk);
    new_data <= m;
    @(posedge pclk);
    new_data <= 8'h00;
  endtask

  // Main sequence of tests.
  initial begin
    {psel, penable, pwrite, irq_source} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    group_mode = 16'h0000;
    global_man = 8'h00;
    new_data = 8'h00;
    clear_value_select = 8'h3C;
    miscompares = 0;
    cmp_count = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_PRELOAD, RST_WORD, "preload");
    rd(OFS_CLEAR, RST_WORD, "clear");
    rd(OFS_LOAD, RST_WORD, "load");
    rd(OFS_GCTRL, RST_WORD, "gctrl");
    rd(OFS_GSTAT, RST_WORD, "gstat");
    rd(12'h0F0, RST_WORD, "unmapped");
    chk("slverr", 32'h0000_0001, {31'h0, err});
    apb(1'b1, OFS_PRELOAD + 12'h00C, 32'h1234_5678);
    rd(OFS_PRELOAD + 12'h00C, 32'h1234_5678, "preload3");
    $display("test reset and map done");
    apb(1'b1, OFS_CLEAR, 32'h0000_00A5);
    repeat (2) @(posedge pclk);
    #1;
    chk("dac_clear", 32'h0000_00A5, {24'h0, dac_clear});
    chk("clear_sel", 32'h0000_003C, {24'h0, clear_sel_out});
    rd(OFS_CLEAR, 32'h0000_00A5, "clear rb");
    // Group 0 stays cleared so a manual load is logged but held.
    for (int m = 3; m >= 0; m--) begin
      group_mode <= 16'(m);
      apb(1'b1, OFS_LOAD, 32'h0000_0001);
      rd(OFS_LOAD, (m <= 1) ? 32'h0000_0001 : RST_WORD, "load mode");
    end
    rd(OFS_GSTAT, 32'h0000_0001, "busy load");
    group_mode <= 16'h0001;
    apb(1'b1, OFS_CLEAR, 32'h0000_0000);
    wait_upd(0, 100);
    rd(OFS_LOAD, RST_WORD, "load self clear");
    $display("test clear and load modes done");
    push(8'h01);
    repeat (3) @(posedge pclk);
    #1;
    chk("xfer_go", 32'h0000_0001, {31'h0, xfer_go[0]});
    apb(1'b1, OFS_LOAD, 32'h0000_0001);
    rd(OFS_LOAD, 32'h0000_0001, "load pending");
    wait_upd(0, 500);
    chk("pend at update", 32'h0, {31'h0, data_pending[0]});
    rd(OFS_LOAD, RST_WORD, "load done");
    group_mode <= 16'h0014;
    global_man <= 8'h06;
    push(8'h04);
    apb(1'b1, OFS_LOAD, 32'h0000_0006);
    rd(OFS_LOAD, 32'h0000_0006, "global held");
    wait_upd(1, 500);
    chk("global pair", 32'h0000_0006, {24'h0, dac_update & 8'h06});
    chk("global pend", 32'h0, {31'h0, data_pending[2]});
    $display("test manual updates done");
    irq_source <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq_out});
    apb(1'b1, OFS_GCTRL, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq enabled", 32'h0000_0001, {31'h0, irq_out});
    apb(1'b1, OFS_GCTRL, 32'h0000_0000);
    $display("test master enable done");
    global_man <= 8'h00;
    apb(1'b1, OFS_PRELOAD, 32'h0000_0001);
    apb(1'b1, OFS_PRELOAD + 12'h004, 32'h0000_0001);
    group_mode <= 16'h000E;
    apb(1'b1, OFS_GCTRL, 32'h0000_0003);
    rd(OFS_GSTAT, 32'h0000_0011, "busy run");
    wait_upd(0, 3000);
    wait_upd(0, 3000);
    chk("spacing", 32'd2000, 32'(n));
    chk("seq pair", 32'h0000_0003, {24'h0, dac_update & 8'h03});
    rd(OFS_GSTAT, 32'h0000_0011, "busy steady");
    push(8'h01);
    apb(1'b1, OFS_GCTRL, 32'h0000_0000);
    // Let the group with no transfer leave drain before busy is read.
    repeat (4) @(posedge pclk);
    rd(OFS_GSTAT, 32'h0000_0001, "busy drain");
    n = 0;
    do begin
      apb(1'b0, OFS_GSTAT, 32'h0000_0000);
      n++;
    end while (rdat !== RST_WORD && n < 100);
    chk("stopped", RST_WORD, rdat);
    chk("xfer idle", 32'h0, {24'h0, xfer_busy});
    $display("test sequencer done");
    wrap_up();
  end
endmodule // quad_converter_sequencer_control_tb_top
`default_nettype wire
